/* rtl/dhc_config_regs.sv */
/*
 * dhc_config_regs: configuration bank for the stereo playback output stage,
 * plus the sample polarity stage and the analog control levels it drives.
 * assumes: a synchronous control port with one-cycle write/read strobes,
 * and a playback sample stream with a one-cycle valid.
 */
// How it works
// - per-channel polarity bit negates that channel's samples; clear by reset.
// - four-bit pull-down code picks strongest, none, weaker taps; some codes reserved.
// - several low pull-down bits set together give the lowest resistance.
// - load-mode bit picks small-load (reset) or large-load amplifier drive.
// - clamp override releases ground clamp at power-down; only pull-down then applies.
// - playback high-pass filter is enabled at reset, fixed rate-scaled corner.
// - per-channel analog mute bits, both muted out of reset.
// - full-scale bit gives 0 dB maximum, or 6 dB lower when set.
// - supply-mode field: four fixed levels or adaptive, adaptive at reset.
`timescale 1ns/10ps
`default_nettype none

module dhc_config_regs
	import dhc_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	input  wire logic [DATA_W-1:0]   reg_wdata,
	output logic      [DATA_W-1:0]   reg_rdata,
	output logic                     reg_rvalid,
	input  wire logic                global_power_down,
	input  wire logic                chan_powered_down,
	input  wire logic                sample_valid,
	input  wire logic [SAMPLE_W-1:0] chan_a_sample,
	input  wire logic [SAMPLE_W-1:0] chan_b_sample,
	output logic                     out_sample_valid,
	output logic      [SAMPLE_W-1:0] out_chan_a_sample,
	output logic      [SAMPLE_W-1:0] out_chan_b_sample,
	output logic                     playback_highpass_enable,
	output logic                     output_load_mode,
	output logic                     output_clamp_to_ground,
	output logic      [2:0]          output_pulldown_tap,
	output logic                     output_pulldown_reserved,
	output logic                     chan_a_analog_mute,
	output logic                     chan_b_analog_mute,
	output logic                     max_volume_select,
	output logic      [2:0]          amp_supply_mode,
	output logic                     amp_supply_adaptive,
	output logic                     amp_supply_reserved
);

	logic [DATA_W-1:0]   dac_polarity_ctrl;
	logic [DATA_W-1:0]   dac_output_ctrl;
	logic [DATA_W-1:0]   headphone_ctrl;
	logic [DATA_W-1:0]   amp_supply_mode_ctrl;
	logic [DATA_W-1:0]   next_dac_polarity_ctrl;
	logic [DATA_W-1:0]   next_dac_output_ctrl;
	logic [DATA_W-1:0]   next_headphone_ctrl;
	logic [DATA_W-1:0]   next_amp_supply_mode_ctrl;
	logic [DATA_W-1:0]   next_reg_rdata;
	logic                next_reg_rvalid;
	logic [SAMPLE_W-1:0] next_out_chan_a_sample;
	logic [SAMPLE_W-1:0] next_out_chan_b_sample;
	logic                pulldown_none;
	dhc_supply_mode_e    supply_mode;

	// keep the reserved bits at their reset pattern, take only writable bits
	function automatic logic [DATA_W-1:0] merge_write(
		input logic [DATA_W-1:0] cur,
		input logic [DATA_W-1:0] wdata,
		input logic [DATA_W-1:0] mask
	);
		return (cur & ~mask) | (wdata & mask);
	endfunction

	// register file
	always_comb begin
		next_dac_polarity_ctrl    = dac_polarity_ctrl;
		next_dac_output_ctrl      = dac_output_ctrl;
		next_headphone_ctrl       = headphone_ctrl;
		next_amp_supply_mode_ctrl = amp_supply_mode_ctrl;
		next_reg_rvalid           = reg_rd;
		next_reg_rdata            = reg_rdata;
		if (reg_wr) begin
			case (reg_addr)
				DAC_POLARITY_CTRL_ADDR: begin
					next_dac_polarity_ctrl = merge_write(dac_polarity_ctrl, reg_wdata,
						DAC_POLARITY_CTRL_MASK);
				end
				DAC_OUTPUT_CTRL_ADDR: begin
					next_dac_output_ctrl = merge_write(dac_output_ctrl, reg_wdata,
						DAC_OUTPUT_CTRL_MASK);
					if (!global_power_down) begin
						next_dac_output_ctrl[PLAYBACK_HIGHPASS_ENABLE_BIT] =
							dac_output_ctrl[PLAYBACK_HIGHPASS_ENABLE_BIT];
					end
				end
				HEADPHONE_CTRL_ADDR: begin
					next_headphone_ctrl = merge_write(headphone_ctrl, reg_wdata,
						HEADPHONE_CTRL_MASK);
				end
				AMP_SUPPLY_MODE_CTRL_ADDR: begin
					next_amp_supply_mode_ctrl = merge_write(amp_supply_mode_ctrl,
						reg_wdata, AMP_SUPPLY_MODE_CTRL_MASK);
				end
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			// reads see the value before any write in the same cycle
			case (reg_addr)
				DAC_POLARITY_CTRL_ADDR:    next_reg_rdata = dac_polarity_ctrl;
				DAC_OUTPUT_CTRL_ADDR:      next_reg_rdata = dac_output_ctrl;
				HEADPHONE_CTRL_ADDR:       next_reg_rdata = headphone_ctrl;
				AMP_SUPPLY_MODE_CTRL_ADDR: next_reg_rdata = amp_supply_mode_ctrl;
				default:                   next_reg_rdata = UNMAPPED_RDATA;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dac_polarity_ctrl    <= DAC_POLARITY_CTRL_RST;
			dac_output_ctrl      <= DAC_OUTPUT_CTRL_RST;
			headphone_ctrl       <= HEADPHONE_CTRL_RST;
			amp_supply_mode_ctrl <= AMP_SUPPLY_MODE_CTRL_RST;
			reg_rdata            <= UNMAPPED_RDATA;
			reg_rvalid           <= 1'b0;
		end else begin
			dac_polarity_ctrl    <= next_dac_polarity_ctrl;
			dac_output_ctrl      <= next_dac_output_ctrl;
			headphone_ctrl       <= next_headphone_ctrl;
			amp_supply_mode_ctrl <= next_amp_supply_mode_ctrl;
			reg_rdata            <= next_reg_rdata;
			reg_rvalid           <= next_reg_rvalid;
		end
	end

	// sample polarity stage
	always_comb begin
		next_out_chan_a_sample = out_chan_a_sample;
		next_out_chan_b_sample = out_chan_b_sample;
		if (sample_valid) begin
			next_out_chan_a_sample = dac_polarity_ctrl[CHAN_A_POLARITY_INVERT_BIT] ?
				negate_sat(chan_a_sample) : chan_a_sample;
			next_out_chan_b_sample = dac_polarity_ctrl[CHAN_B_POLARITY_INVERT_BIT] ?
				negate_sat(chan_b_sample) : chan_b_sample;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			out_sample_valid  <= 1'b0;
			out_chan_a_sample <= '0;
			out_chan_b_sample <= '0;
		end else begin
			out_sample_valid  <= sample_valid;
			out_chan_a_sample <= next_out_chan_a_sample;
			out_chan_b_sample <= next_out_chan_b_sample;
		end
	end

	dhc_pulldown_decode u_pulldown (
		.code          (dac_output_ctrl[OUTPUT_PULLDOWN_SELECT_MSB:OUTPUT_PULLDOWN_SELECT_LSB]),
		.tap_enable    (output_pulldown_tap),
		.pulldown_none (pulldown_none),
		.code_reserved (output_pulldown_reserved)
	);

	assign playback_highpass_enable = dac_output_ctrl[PLAYBACK_HIGHPASS_ENABLE_BIT];
	assign output_load_mode         = dac_output_ctrl[OUTPUT_LOAD_MODE_BIT];
	assign output_clamp_to_ground   = chan_powered_down &&
		!dac_output_ctrl[OUTPUT_CLAMP_OVERRIDE_BIT];
	assign chan_a_analog_mute       = headphone_ctrl[CHAN_A_ANALOG_MUTE_BIT];
	assign chan_b_analog_mute       = headphone_ctrl[CHAN_B_ANALOG_MUTE_BIT];
	assign max_volume_select        = headphone_ctrl[MAX_VOLUME_SELECT_BIT];

	assign supply_mode         = dhc_supply_mode_e'(
		amp_supply_mode_ctrl[AMP_SUPPLY_MODE_MSB:AMP_SUPPLY_MODE_LSB]);
	assign amp_supply_mode     = supply_mode;
	assign amp_supply_adaptive = (supply_mode == SUPPLY_ADAPTIVE);
	// reserved codes are stored as written; the flag lets the analog side ignore them
	assign amp_supply_reserved = (supply_mode == SUPPLY_RSVD0) ||
		(supply_mode == SUPPLY_RSVD5) || (supply_mode == SUPPLY_RSVD6);

endmodule

`default_nettype wire

/* rtl/dhc_pkg.sv */
/*
 * dhc_pkg: register offsets, field positions, reset values and codes for the
 * playback output stage configuration bank.
 * assumes: 16-bit register addresses and 8-bit registers on the control port.
 */
package dhc_pkg;

	localparam int unsigned ADDR_W   = 16;
	localparam int unsigned DATA_W   = 8;
	localparam int unsigned SAMPLE_W = 24;

	// register offsets
	localparam logic [ADDR_W-1:0] DAC_POLARITY_CTRL_ADDR    = 16'h1F01;
	localparam logic [ADDR_W-1:0] DAC_OUTPUT_CTRL_ADDR      = 16'h1F06;
	localparam logic [ADDR_W-1:0] HEADPHONE_CTRL_ADDR       = 16'h2001;
	localparam logic [ADDR_W-1:0] AMP_SUPPLY_MODE_CTRL_ADDR = 16'h2101;

	// reset values, reserved bits included as they read back
	localparam logic [DATA_W-1:0] DAC_POLARITY_CTRL_RST    = 8'h00;
	localparam logic [DATA_W-1:0] DAC_OUTPUT_CTRL_RST      = 8'h02;
	localparam logic [DATA_W-1:0] HEADPHONE_CTRL_RST       = 8'h0D;
	localparam logic [DATA_W-1:0] AMP_SUPPLY_MODE_CTRL_RST = 8'h07;
	localparam logic [DATA_W-1:0] UNMAPPED_RDATA           = 8'h00;

	// writable bit masks; other bits are reserved
	localparam logic [DATA_W-1:0] DAC_POLARITY_CTRL_MASK    = 8'h03;
	localparam logic [DATA_W-1:0] DAC_OUTPUT_CTRL_MASK      = 8'hFE;
	localparam logic [DATA_W-1:0] HEADPHONE_CTRL_MASK       = 8'h0E;
	localparam logic [DATA_W-1:0] AMP_SUPPLY_MODE_CTRL_MASK = 8'h07;

	// field positions
	localparam int unsigned CHAN_A_POLARITY_INVERT_BIT   = 0;
	localparam int unsigned CHAN_B_POLARITY_INVERT_BIT   = 1;
	localparam int unsigned PLAYBACK_HIGHPASS_ENABLE_BIT = 1;
	localparam int unsigned OUTPUT_CLAMP_OVERRIDE_BIT    = 2;
	localparam int unsigned OUTPUT_LOAD_MODE_BIT         = 3;
	localparam int unsigned OUTPUT_PULLDOWN_SELECT_LSB   = 4;
	localparam int unsigned OUTPUT_PULLDOWN_SELECT_MSB   = 7;
	localparam int unsigned MAX_VOLUME_SELECT_BIT        = 1;
	localparam int unsigned CHAN_A_ANALOG_MUTE_BIT       = 2;
	localparam int unsigned CHAN_B_ANALOG_MUTE_BIT       = 3;
	localparam int unsigned AMP_SUPPLY_MODE_LSB          = 0;
	localparam int unsigned AMP_SUPPLY_MODE_MSB          = 2;

	// pull-down codes: bit 3 set means the low three bits pick string taps
	localparam int unsigned PD_TAP_WEAK   = 0;
	localparam int unsigned PD_TAP_MEDIUM = 1;
	localparam int unsigned PD_TAP_STRONG = 2;
	localparam int unsigned PD_TAP_SEL    = 3;
	localparam logic [3:0]  PD_CODE_RSVD_LO = 4'hB;
	localparam logic [3:0]  PD_CODE_RSVD_HI = 4'hD;

	// high-pass corner in hertz at a 48 kHz internal rate, scales with rate
	localparam real HPF_CORNER_HZ_AT_48K = 0.935;

	typedef enum logic [2:0] {
		SUPPLY_RSVD0    = 3'h0,
		SUPPLY_FIXED_M0 = 3'h1,
		SUPPLY_FIXED_M1 = 3'h2,
		SUPPLY_FIXED_M2 = 3'h3,
		SUPPLY_FIXED_M3 = 3'h4,
		SUPPLY_RSVD5    = 3'h5,
		SUPPLY_RSVD6    = 3'h6,
		SUPPLY_ADAPTIVE = 3'h7
	} dhc_supply_mode_e;

	// negate a sample, saturating the most negative value
	function automatic logic [SAMPLE_W-1:0] negate_sat(input logic [SAMPLE_W-1:0] s);
		logic [SAMPLE_W-1:0] r;
		r = SAMPLE_W'(~s + 1'b1);
		if (s == {1'b1, {(SAMPLE_W-1){1'b0}}}) begin
			r = {1'b0, {(SAMPLE_W-1){1'b1}}};
		end
		return r;
	endfunction

endpackage

/* rtl/dhc_pulldown_decode.sv */
/*
 * dhc_pulldown_decode: turns the pull-down select code into one-hot or all-off string
 * tap enables and a reserved-code flag.
 * assumes: the code is a stable register field; output is combinational.
 */
`timescale 1ns/10ps
`default_nettype none

module dhc_pulldown_decode
	import dhc_pkg::*;
(
	input  wire logic [3:0] code,
	output logic      [2:0] tap_enable,
	output logic            pulldown_none,
	output logic            code_reserved
);

	always_comb begin
		tap_enable    = 3'h0;
		pulldown_none = 1'b0;
		code_reserved = (code == PD_CODE_RSVD_LO) || (code >= PD_CODE_RSVD_HI);
		if (!code[PD_TAP_SEL]) begin
			tap_enable[PD_TAP_STRONG] = 1'b1;
		end else if (code[PD_TAP_STRONG]) begin
			tap_enable[PD_TAP_STRONG] = 1'b1;
		end else if (code[PD_TAP_MEDIUM]) begin
			tap_enable[PD_TAP_MEDIUM] = 1'b1;
		end else if (code[PD_TAP_WEAK]) begin
			tap_enable[PD_TAP_WEAK] = 1'b1;
		end else begin
			pulldown_none = 1'b1;
		end
	end

endmodule

`default_nettype wire

/* verif/dhc_config_regs_bench.sv */
/* dhc_config_regs_bench: register and sample checks for the config bank.
   assumes: dhc_pkg and dhc_props compiled first; 50 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module dhc_config_regs_bench import dhc_pkg::*;;
	logic                clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid;
	logic [ADDR_W-1:0]   reg_addr;
	logic [DATA_W-1:0]   reg_wdata, reg_rdata;
	logic                global_power_down, chan_powered_down, sample_valid, osv;
	logic [SAMPLE_W-1:0] a_in, b_in, a_out, b_out;
	logic                hpf, load, clamp, pd_rsvd, mute_a, mute_b, vol, adapt, s_rsvd;
	logic [2:0]          tap, mode;
	int                  n_errors = 0;
	int                  tests_run = 0;
	dhc_config_regs u_dhc_config_regs (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .global_power_down(global_power_down),
		.chan_powered_down(chan_powered_down), .sample_valid(sample_valid),
		.chan_a_sample(a_in), .chan_b_sample(b_in), .out_sample_valid(osv),
		.out_chan_a_sample(a_out), .out_chan_b_sample(b_out), .playback_highpass_enable(hpf),
		.output_load_mode(load), .output_clamp_to_ground(clamp), .output_pulldown_tap(tap),
		.output_pulldown_reserved(pd_rsvd), .chan_a_analog_mute(mute_a),
		.chan_b_analog_mute(mute_b), .max_volume_select(vol), .amp_supply_mode(mode),
		.amp_supply_adaptive(adapt), .amp_supply_reserved(s_rsvd));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// tasks start on an edge and leave one idle edge so strobes never double-drive
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rvalid, 1'b1)
		`CHK(reg_rdata, e)
		@(posedge clk_sys);
	endtask
	task automatic smp(input logic [23:0] a, b, ea, eb);
		a_in <= a;
		b_in <= b;
		sample_valid <= 1'b1;
		@(posedge clk_sys);
		sample_valid <= 1'b0;
		#1;
		`CHK({osv, a_out, b_out}, {1'b1, ea, eb})
		@(posedge clk_sys);
	endtask
	// 1011 resolves to the 5.8k tap, the lowest resistance among those picked
	function automatic logic [2:0] pd_exp(input logic [3:0] c);
		if (c[3] && c < 4'hC) return c[1] ? 3'b010 : {2'b00, c[0]};
		return 3'b100;
	endfunction
	task automatic summarize;
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		{reg_wr, reg_rd, reg_addr, reg_wdata, sample_valid, a_in, b_in} = '0;
		global_power_down = 1'b1;
		chan_powered_down = 1'b0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		`CHK({mute_a, mute_b, hpf, adapt, vol, load}, 6'b111100)
		rd(16'h1F01, 8'h00);
		rd(16'h1F06, 8'h02);
		rd(16'h2001, 8'h0D);
		rd(16'h2101, 8'h07);
		rd(16'h1F02, 8'h00);
		smp(24'h000001, 24'h800000, 24'h000001, 24'h800000);
		wr(16'h1F01, 8'hFF);
		rd(16'h1F01, 8'h03);
		smp(24'h000001, 24'h800000, 24'hFFFFFF, 24'h7FFFFF);
		wr(16'h1F01, 8'h01);
		smp(24'h000010, 24'h000010, 24'hFFFFF0, 24'h000010);
		global_power_down <= 1'b0;
		// path down before the load-mode change
		chan_powered_down <= 1'b1;
		wr(16'h1F06, 8'h0C);
		`CHK({load, clamp, hpf}, 3'b101)
		rd(16'h1F06, 8'h0E);
		// filter bit may change only under global power-down
		global_power_down <= 1'b1;
		wr(16'h1F06, 8'h00);
		`CHK({load, clamp, hpf}, 3'b010)
		// path up again once the load mode is settled
		chan_powered_down <= 1'b0;
		for (int c = 0; c < 16; c++) begin
			wr(16'h1F06, {c[3:0], 4'h2});
			`CHK({tap, pd_rsvd}, {pd_exp(c[3:0]), c == 11 || c > 12})
		end
		`CHK(clamp, 1'b0)
		wr(16'h2001, 8'h00);
		`CHK({mute_b, mute_a, vol}, 3'b000)
		rd(16'h2001, 8'h01);
		wr(16'h2001, 8'h0A);
		`CHK({mute_b, mute_a, vol}, 3'b101)
		for (int m = 0; m < 8; m++) begin
			wr(16'h2101, 8'(m));
			`CHK({mode, adapt, s_rsvd}, {m[2:0], m == 7, m == 0 || m == 5 || m == 6})
			rd(16'h2101, 8'(m));
		end
		summarize();
	end
	// the run needs about 120 cycles; this margin only catches a hang
	initial begin
		repeat (4000) @(posedge clk_sys);
		n_errors++;
		summarize();
	end
endmodule
`default_nettype wire

/* verif/dhc_props.sv */
/* dhc_props: port-level checks for the playback output config bank.
   assumes: bound to dhc_config_regs, one clock, sync active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module dhc_props (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        reg_rd,
	input wire logic        reg_rvalid,
	input wire logic        global_power_down,
	input wire logic        chan_powered_down,
	input wire logic        sample_valid,
	input wire logic        out_sample_valid,
	input wire logic [23:0] out_chan_a_sample,
	input wire logic        playback_highpass_enable,
	input wire logic        output_clamp_to_ground,
	input wire logic [2:0]  output_pulldown_tap,
	input wire logic        chan_a_analog_mute,
	input wire logic        chan_b_analog_mute,
	input wire logic [2:0]  amp_supply_mode,
	input wire logic        amp_supply_adaptive,
	input wire logic        amp_supply_reserved
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_rvalid; reg_rvalid == $past(reg_rd); endproperty
	a_rvalid: assert property (p_rvalid) else $error("read valid off");
	property p_svalid; out_sample_valid == $past(sample_valid); endproperty
	a_svalid: assert property (p_svalid) else $error("sample valid off");
	property p_shold; !sample_valid |=> $stable(out_chan_a_sample); endproperty
	a_shold: assert property (p_shold) else $error("sample moved");
	property p_clamp; !chan_powered_down |-> !output_clamp_to_ground; endproperty
	a_clamp: assert property (p_clamp) else $error("clamp while powered");
	property p_tap; $onehot0(output_pulldown_tap); endproperty
	a_tap: assert property (p_tap) else $error("several taps on");
	property p_filt; !global_power_down |=> $stable(playback_highpass_enable); endproperty
	a_filt: assert property (p_filt) else $error("filter bit moved");
	property p_adapt; amp_supply_adaptive == (amp_supply_mode == 3'h7); endproperty
	a_adapt: assert property (p_adapt) else $error("adaptive flag off");
	property p_srsvd;
		amp_supply_reserved == (amp_supply_mode inside {3'h0, 3'h5, 3'h6});
	endproperty
	a_srsvd: assert property (p_srsvd) else $error("reserved flag off");
	property p_rst; $rose(rst_n) |-> chan_a_analog_mute && chan_b_analog_mute; endproperty
	a_rst: assert property (p_rst) else $error("mutes not set");
endmodule
bind dhc_config_regs dhc_props u_dhc_props (.clk_sys(clk_sys), .rst_n(rst_n),
	.reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .global_power_down(global_power_down),
	.chan_powered_down(chan_powered_down), .sample_valid(sample_valid),
	.out_sample_valid(out_sample_valid), .out_chan_a_sample(out_chan_a_sample),
	.playback_highpass_enable(playback_highpass_enable),
	.output_clamp_to_ground(output_clamp_to_ground), .output_pulldown_tap(output_pulldown_tap),
	.chan_a_analog_mute(chan_a_analog_mute), .chan_b_analog_mute(chan_b_analog_mute),
	.amp_supply_mode(amp_supply_mode), .amp_supply_adaptive(amp_supply_adaptive),
	.amp_supply_reserved(amp_supply_reserved));
`default_nettype wire
